// [logic/prm_pkg.sv]
`default_nettype none
package prm_pkg;
    // parameter block layout
    localparam int PRM_LEN = 12;
    localparam logic [3:0] PRM_LAST = 4'hb;
    localparam logic [3:0] PRM_FULL = 4'hc;
    localparam logic [3:0] PRM_OVER = 4'hd;
    localparam int B_CHAR = 0;
    localparam int B_DIAG = 5;
    localparam int B_TERM = 7;
    localparam int B_FMT = 9;
    localparam int B_REACT = 10;
    localparam int B_DLEN = 11;
    // bit positions
    localparam int BIT_START_OFF = 0;
    localparam int BIT_STOP_OFF = 1;
    localparam int BIT_WD_1MS = 2;
    localparam int BIT_FAIL_SAFE = 6;
    localparam int BIT_C1_EN = 7;
    localparam int BIT_DIAG_2B = 1;
    localparam int BIT_TB_ARST = 0;
    localparam int BIT_TB_ADIAG = 1;
    localparam int BIT_DIG_DIAG_OUT = 4;
    localparam int BIT_BIG_END = 3;
    localparam int REACT_FB_LO = 0;
    localparam int REACT_TB_LO = 2;
    // reaction codes
    localparam logic [1:0] REACT_ZERO = 2'h1;
    localparam logic [1:0] REACT_HOLD = 2'h2;
    // diagnostic length range
    localparam logic [7:0] DLEN_MIN = 8'h10;
    localparam logic [7:0] DLEN_MAX = 8'h40;
    localparam logic [7:0] DLEN_STEP = 8'h07;
    // reserved bits cleared, fixed bits forced, byte 11 first
    localparam logic [PRM_LEN-1:0][7:0] PRM_KEEP = {8'hff, 8'h0f, 8'h08, 8'h00, 8'h13, 8'h00,
        8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc7};
    localparam logic [PRM_LEN-1:0][7:0] PRM_FORCE = {8'h00, 8'h00, 8'h63, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // controller registers
    localparam logic [7:0] REG_CTRL = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam int CTRL_GO = 0;
    localparam int CTRL_USER = 1;
    localparam int CTRL_CLOSE = 2;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WD_1MS_NS = 1000000;
    localparam int WD_10MS_NS = 10000000;
    localparam int IO_W = 8;

    typedef struct packed {
        logic start_chk_en;
        logic stop_chk_en;
        logic wd_1ms;
        logic fail_safe;
        logic c1_enable;
        logic diag_2byte;
        logic tb_auto_reset;
        logic tb_auto_diag;
        logic dig_diag_in_image;
        logic big_endian;
        logic [1:0] fb_react;
        logic [1:0] tb_react;
        logic [7:0] diag_len;
    } opt_t;

    localparam opt_t OPT_RESET = '{start_chk_en: 1'b1, stop_chk_en: 1'b1, wd_1ms: 1'b0,
        fail_safe: 1'b0, c1_enable: 1'b0, diag_2byte: 1'b0, tb_auto_reset: 1'b0,
        tb_auto_diag: 1'b0, dig_diag_in_image: 1'b1, big_endian: 1'b0,
        fb_react: REACT_ZERO, tb_react: REACT_ZERO, diag_len: DLEN_MIN};

    function automatic logic dlen_ok(input logic [7:0] len);
        return (len >= DLEN_MIN) && (len <= DLEN_MAX) && ((len & DLEN_STEP) == 8'h00);
    endfunction

    function automatic logic react_ok(input logic [1:0] code);
        return (code == REACT_ZERO) || (code == REACT_HOLD);
    endfunction
endpackage
`default_nettype wire

// [logic/prm_link_if.sv]
`default_nettype none
interface prm_link_if;
    logic conn;
    logic frame;
    logic valid;
    logic [7:0] data;
    logic ack;
    logic fault;
    modport master (output conn, output frame, output valid, output data,
        input ack, input fault);
    modport slave (input conn, input frame, input valid, input data,
        output ack, output fault);
endinterface
`default_nettype wire

// [logic/prm_check.sv]
`default_nettype none
module prm_check import prm_pkg::*; (
    // captured parameter bytes
    input wire logic [PRM_LEN-1:0][7:0] prm,
    // decoded options and verdict
    output opt_t dec,
    output logic ok
);
    always_comb begin
        dec.start_chk_en = ~prm[B_CHAR][BIT_START_OFF];
        dec.stop_chk_en = ~prm[B_CHAR][BIT_STOP_OFF];
        dec.wd_1ms = prm[B_CHAR][BIT_WD_1MS];
        dec.fail_safe = prm[B_CHAR][BIT_FAIL_SAFE];
        dec.c1_enable = prm[B_CHAR][BIT_C1_EN];
        dec.diag_2byte = prm[B_DIAG][BIT_DIAG_2B];
        dec.tb_auto_reset = prm[B_TERM][BIT_TB_ARST];
        dec.tb_auto_diag = prm[B_TERM][BIT_TB_ADIAG];
        dec.dig_diag_in_image = ~prm[B_TERM][BIT_DIG_DIAG_OUT];
        dec.big_endian = prm[B_FMT][BIT_BIG_END];
        dec.fb_react = prm[B_REACT][REACT_FB_LO +: 2];
        dec.tb_react = prm[B_REACT][REACT_TB_LO +: 2];
        dec.diag_len = prm[B_DLEN];
        // reserved bits are not checked: a stray one is harmless here
        ok = react_ok(dec.fb_react) && react_ok(dec.tb_react) && dlen_ok(dec.diag_len);
    end
endmodule
`default_nettype wire

// [logic/prm_slave.sv]
// Contract
// - parameters delivered once per connection, latched
// - received parameters override local configuration; a later local write still replaces them
// - master omits bytes to keep local settings
// - byte0 bits0,1 set disable start/stop checks
// - byte0 bit2 watchdog base 10ms or 1ms
// - byte0 bit6 fail-safe, bit7 class-1 connection
// - master sends zero in reserved positions
// - byte5 bit1 selects two-byte diagnostic path
// - byte7 bit0 auto terminal-bus reset
// - byte7 bit1 automatic terminal diagnostics
// - byte7 bit4 clear maps digital diagnostics
// - byte9 bit3 byte order, fixed bits
// - byte10 bits1:0 fieldbus error output reaction
// - byte10 bits3:2 terminal-bus error input reaction
// - byte11 diagnostic length limit, 16..64 step 8
//
// Added by the designer: the register offsets and strobed register access.
`default_nettype none
module prm_slave import prm_pkg::*; #(
    parameter int unsigned TICK_1MS = WD_1MS_NS / CLK_PERIOD_NS,
    parameter int unsigned TICK_10MS = WD_10MS_NS / CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // link to the master
    prm_link_if.slave link,
    // local configuration interface
    input wire logic loc_wr,
    input wire opt_t loc_opt,
    // response watchdog
    input wire logic [7:0] wd_units,
    input wire logic data_ex,
    // error sources
    input wire logic fb_fault,
    input wire logic tb_fault,
    // process data through the reactions
    input wire logic [IO_W-1:0] tb_out_in,
    input wire logic [IO_W-1:0] dp_in_in,
    // diagnostic length request
    input wire logic [7:0] diag_want,
    // results
    output opt_t opt,
    output logic prm_locked,
    output logic wd_expired,
    output logic [IO_W-1:0] tb_out,
    output logic [IO_W-1:0] dp_in,
    output logic [7:0] diag_grant
);
    typedef struct packed {
        logic [PRM_LEN-1:0][7:0] shadow;
        logic [3:0] cnt;
        logic frame_q;
        logic locked;
        opt_t opt;
        logic ack;
        logic fault;
        logic [19:0] pre;
        logic [7:0] units;
        logic wd_exp;
        logic [IO_W-1:0] tb_out;
        logic [IO_W-1:0] dp_in;
        logic [7:0] diag_grant;
    } slave_state_t;

    localparam slave_state_t SLAVE_RESET = '{
        shadow: '0,
        cnt: 4'h0,
        frame_q: 1'b0,
        locked: 1'b0,
        opt: OPT_RESET,
        ack: 1'b0,
        fault: 1'b0,
        pre: 20'h00000,
        units: 8'h00,
        wd_exp: 1'b0,
        tb_out: '0,
        dp_in: '0,
        diag_grant: 8'h00
    };

    slave_state_t state_reg;
    slave_state_t state_next;
    opt_t chk_opt;
    logic chk_ok;
    logic [3:0] base;
    logic [19:0] tick_len;
    logic fb_bad;

    // one helper for both directions keeps the two reactions from drifting apart
    function automatic logic [IO_W-1:0] react(input logic bad, input logic [1:0] code,
            input logic [IO_W-1:0] live, input logic [IO_W-1:0] last);
        if (!bad) begin
            return live;
        end
        // any code but force-to-zero holds, so a stray local code never drops outputs
        if (code == REACT_ZERO) begin
            return '0;
        end
        return last;
    endfunction

    function automatic logic [7:0] unit_step(input logic [7:0] units);
        return units + 8'h01;
    endfunction

    // the decoder reads the shadow, so the verdict covers the block as it stood at frame end
    prm_check prm_check_inst (
        .prm(state_reg.shadow),
        .dec(chk_opt),
        .ok(chk_ok)
    );

    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.frame_q = link.frame;
        base = (link.frame && !state_reg.frame_q) ? 4'h0 : state_reg.cnt;
        tick_len = state_reg.opt.wd_1ms ? 20'(TICK_1MS - 1) : 20'(TICK_10MS - 1);
        fb_bad = fb_fault || state_reg.wd_exp;

        // a new connection allows one more parameter block
        if (!link.conn) begin
            state_next.locked = 1'b0;
        end

        // byte capture; counter saturates so an overlong block is caught
        if (link.frame) begin
            state_next.cnt = base;
            if (link.valid) begin
                if (base <= PRM_LAST) begin
                    state_next.shadow[base] = link.data;
                end
                if (base != PRM_OVER) begin
                    state_next.cnt = base + 4'h1;
                end
            end
        end

        // local writes first so that a block ending in the same cycle wins
        if (loc_wr) begin
            state_next.opt = loc_opt;
        end

        // frame end: judge the block
        if (state_reg.frame_q && !link.frame) begin
            state_next.ack = 1'b1;
            if (state_reg.locked || !link.conn) begin
                state_next.fault = 1'b1;
            end else if (state_reg.cnt == 4'h0) begin
                state_next.fault = 1'b0;
                state_next.locked = 1'b1;
            end else if (state_reg.cnt == PRM_FULL && chk_ok) begin
                state_next.fault = 1'b0;
                state_next.locked = 1'b1;
                state_next.opt = chk_opt;
            end else begin
                state_next.fault = 1'b1;
            end
        end

        // expiry latches until data exchange resumes and counts as a fieldbus error
        // response watchdog; zero units switches it off
        if (data_ex || wd_units == 8'h00) begin
            state_next.pre = 20'h00000;
            state_next.units = 8'h00;
            state_next.wd_exp = 1'b0;
        end else if (!state_reg.wd_exp) begin
            if (state_reg.pre >= tick_len) begin
                state_next.pre = 20'h00000;
                state_next.units = unit_step(state_reg.units);
                if (unit_step(state_reg.units) >= wd_units) begin
                    state_next.wd_exp = 1'b1;
                end
            end else begin
                state_next.pre = state_reg.pre + 20'h00001;
            end
        end

        // output reaction to fieldbus trouble; other codes hold
        state_next.tb_out = react(fb_bad, state_reg.opt.fb_react, tb_out_in,
            state_reg.tb_out);

        // input reaction to terminal-bus trouble
        state_next.dp_in = react(tb_fault, state_reg.opt.tb_react, dp_in_in,
            state_reg.dp_in);

        // never answer longer than the agreed diagnostic length
        state_next.diag_grant = (diag_want > state_reg.opt.diag_len) ?
            state_reg.opt.diag_len : diag_want;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= SLAVE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.ack = state_reg.ack;
    assign link.fault = state_reg.fault;
    assign opt = state_reg.opt;
    assign prm_locked = state_reg.locked;
    assign wd_expired = state_reg.wd_exp;
    assign tb_out = state_reg.tb_out;
    assign dp_in = state_reg.dp_in;
    assign diag_grant = state_reg.diag_grant;
endmodule
`default_nettype wire

// [logic/prm_master.sv]
`default_nettype none
module prm_master import prm_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // link to the slave
    prm_link_if.master link,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_SEND = 2'b01,
        M_CLOSE = 2'b11,
        M_WAIT = 2'b10
    } mstate_t;

    typedef struct packed {
        mstate_t st;
        logic [PRM_LEN-1:0][7:0] bytes;
        logic user_en;
        logic [3:0] idx;
        logic conn;
        logic frame;
        logic valid;
        logic [7:0] data;
        logic done;
        logic fault;
        logic len_err;
        logic [7:0] rdata;
    } master_state_t;

    localparam master_state_t MASTER_RESET = '{st: M_IDLE, bytes: '0, user_en: 1'b0,
        idx: 4'h0, conn: 1'b0, frame: 1'b0, valid: 1'b0, data: 8'h00, done: 1'b0,
        fault: 1'b0, len_err: 1'b0, rdata: 8'h00};

    master_state_t state_reg;
    master_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.valid = 1'b0;
        state_next.rdata = 8'h00;
        if (rd) begin
            if (addr < 8'(PRM_LEN)) begin
                state_next.rdata = state_reg.bytes[addr[3:0]];
            end else if (addr == REG_CTRL) begin
                state_next.rdata = {6'h00, state_reg.user_en, 1'b0};
            end else if (addr == REG_STAT) begin
                state_next.rdata = {3'h0, state_reg.len_err, state_reg.fault,
                    state_reg.done, state_reg.conn, state_reg.st != M_IDLE};
            end
        end
        if (wr) begin
            if (addr < 8'(PRM_LEN)) begin
                state_next.bytes[addr[3:0]] = wdata;
            end else if (addr == REG_CTRL) begin
                state_next.user_en = wdata[CTRL_USER];
                if (wdata[CTRL_CLOSE]) begin
                    state_next.conn = 1'b0;
                end else if (wdata[CTRL_GO] && state_reg.st == M_IDLE) begin
                    // with the user bit set, a block is not started while the length byte is illegal; later writes to it are not checked
                    if (wdata[CTRL_USER] && !dlen_ok(state_reg.bytes[B_DLEN])) begin
                        state_next.len_err = 1'b1;
                    end else begin
                        state_next.len_err = 1'b0;
                        state_next.done = 1'b0;
                        state_next.fault = 1'b0;
                        state_next.conn = 1'b1;
                        state_next.frame = 1'b1;
                        state_next.idx = 4'h0;
                        state_next.st = M_SEND;
                    end
                end
            end
        end
        unique case (state_reg.st)
            M_IDLE: begin
            end
            M_SEND: begin
                if (!state_reg.user_en) begin
                    state_next.st = M_CLOSE;
                end else begin
                    state_next.valid = 1'b1;
                    state_next.data = (state_reg.bytes[state_reg.idx] & PRM_KEEP[state_reg.idx])
                        | PRM_FORCE[state_reg.idx];
                    state_next.idx = state_reg.idx + 4'h1;
                    if (state_reg.idx == PRM_LAST) begin
                        state_next.st = M_CLOSE;
                    end
                end
            end
            M_CLOSE: begin
                state_next.frame = 1'b0;
                state_next.st = M_WAIT;
            end
            M_WAIT: begin
                if (link.ack) begin
                    state_next.done = 1'b1;
                    state_next.fault = link.fault;
                    state_next.st = M_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= MASTER_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.conn = state_reg.conn;
    assign link.frame = state_reg.frame;
    assign link.valid = state_reg.valid;
    assign link.data = state_reg.data;
    assign rdata = state_reg.rdata;
endmodule
`default_nettype wire

// [verification/prm_link_asserts.sv]
`default_nettype none
module prm_link_asserts import prm_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // link signals
    input wire logic conn,
    input wire logic frame,
    input wire logic valid,
    input wire logic [7:0] data,
    input wire logic ack,
    input wire logic fault
);
    timeunit 1ns;
    timeprecision 1ps;
    // reserved bits per byte, byte 0 first
    localparam logic [7:0] RSV [12] = '{8'h38, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfd,
        8'hff, 8'hec, 8'hff, 8'h00, 8'hf0, 8'h00};
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    // byte index within a block; holds the count when frame drops
    always_comb begin
        cnt_next = cnt_reg;
        if (!frame) cnt_next = 5'h00;
        else if (valid) cnt_next = cnt_reg + 5'h01;
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) cnt_reg <= 5'h00;
        else cnt_reg <= cnt_next;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_due; $fell(frame) |=> ack; endproperty
    a_ack_due: assert property (p_ack_due) else $error("no ack after block");
    property p_ack_cause; $rose(ack) |-> !$past(frame) && $past(frame, 2); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without block");
    property p_in_frame; valid |-> frame && conn; endproperty
    a_in_frame: assert property (p_in_frame) else $error("byte outside block");
    property p_count; $fell(frame) |-> cnt_reg == 5'd0 || cnt_reg == 5'd12; endproperty
    a_count: assert property (p_count) else $error("bad byte count");
    property p_fault_hold; $changed(fault) |-> ack; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault moved without ack");
    property p_rsv; valid && cnt_reg < 5'd12 |-> (data & RSV[cnt_reg[3:0]]) == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_fixed; valid && cnt_reg == 5'd9 |-> (data & 8'hf7) == 8'h63; endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
    property p_dlen;
        valid && cnt_reg == 5'd11 |-> data >= 8'h10 && data <= 8'h40 && data[2:0] == 3'h0;
    endproperty
    a_dlen: assert property (p_dlen) else $error("length out of range");
    c_ok: cover property (ack && !fault);
    c_bad: cover property (ack && fault);
    c_empty: cover property ($fell(frame) && cnt_reg == 5'd0);
endmodule
`default_nettype wire

// [verification/test_fieldbus_slave_param_decoder.sv]
`default_nettype none
module test_fieldbus_slave_param_decoder import prm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic f;
        opt_t o;
    } exp_t;
    logic mclk, reset_n, wr, rd, loc_wr, data_ex, fb_fault, tb_fault, prm_locked, wd_expired, ok;
    logic [7:0] addr, wdata, rdata, wd_units, diag_want, diag_grant, hold_tb, hold_dp;
    logic [IO_W-1:0] tb_out_in, dp_in_in, tb_out, dp_in;
    opt_t loc_opt, opt, exp_opt, lo;
    exp_t q[$];
    exp_t mon_e;
    int fail_count, tests_run, cyc, wait_n;
    logic [7:0] b [PRM_LEN];
    localparam int TICK_FAST = 10;
    localparam int TICK_SLOW = 100;
    prm_link_if prm_link_if_inst();
    prm_master prm_master_inst(.mclk(mclk), .reset_n(reset_n), .link(prm_link_if_inst.master),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    prm_slave #(.TICK_1MS(TICK_FAST), .TICK_10MS(TICK_SLOW)) prm_slave_inst(.mclk(mclk),
        .reset_n(reset_n), .link(prm_link_if_inst.slave), .loc_wr(loc_wr), .loc_opt(loc_opt),
        .wd_units(wd_units),
        .data_ex(data_ex), .fb_fault(fb_fault), .tb_fault(tb_fault), .tb_out_in(tb_out_in),
        .dp_in_in(dp_in_in), .diag_want(diag_want), .opt(opt), .prm_locked(prm_locked),
        .wd_expired(wd_expired), .tb_out(tb_out), .dp_in(dp_in), .diag_grant(diag_grant));
    prm_link_asserts prm_link_asserts_inst(.mclk(mclk), .reset_n(reset_n),
        .conn(prm_link_if_inst.conn), .frame(prm_link_if_inst.frame),
        .valid(prm_link_if_inst.valid), .data(prm_link_if_inst.data),
        .ack(prm_link_if_inst.ack), .fault(prm_link_if_inst.fault));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatched %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // gap cycle after each strobe keeps one assignment per signal per step
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk(rdata & m, e);
        @(posedge mclk);
    endtask
    task automatic go(input logic [7:0] c);
        wreg(REG_CTRL, c);
        repeat (30) begin
            @(posedge mclk);
            if (prm_link_if_inst.ack) break;
        end
        @(posedge mclk);
    endtask
    function automatic opt_t decode();
        opt_t o;
        o.start_chk_en = ~b[0][0];
        o.stop_chk_en = ~b[0][1];
        o.wd_1ms = b[0][2];
        o.fail_safe = b[0][6];
        o.c1_enable = b[0][7];
        o.diag_2byte = b[5][1];
        o.tb_auto_reset = b[7][0];
        o.tb_auto_diag = b[7][1];
        o.dig_diag_in_image = ~b[7][4];
        o.big_endian = b[9][3];
        o.fb_react = b[10][1:0];
        o.tb_react = b[10][3:2];
        o.diag_len = b[11];
        return o;
    endfunction
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // result watcher: every ack retires the oldest note
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            stop_test();
        end else if (reset_n && prm_link_if_inst.ack) begin
            if (q.size() == 0) chk(32'h1, 32'h0);
            else begin
                mon_e = q.pop_front();
                chk(prm_link_if_inst.fault, mon_e.f);
                chk(opt, mon_e.o);
            end
        end
    end
    initial begin
        {reset_n, wr, rd, loc_wr, data_ex, fb_fault, tb_fault} = '0;
        {addr, wdata, wd_units, diag_want, tb_out_in, dp_in_in} = '0;
        loc_opt = OPT_RESET;
        void'($urandom(32'he89e1439));
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        chk(opt, OPT_RESET);
        chk(prm_locked, 1'b0);
        @(posedge mclk);
        wreg(8'h30, 8'hff);
        rreg(8'h30, 8'hff, 8'h00);
        $display("reset test done");
        // local write before each block; failing blocks must keep it
        for (int i = 0; i < 8; i++) begin
            wreg(REG_CTRL, 8'h04);
            loc_opt <= opt_t'($urandom);
            loc_wr <= 1'b1;
            @(posedge mclk);
            loc_wr <= 1'b0;
            exp_opt = loc_opt;
            foreach (b[k]) b[k] = 8'($urandom);
            b[10][1:0] = i[1:0];
            b[10][3:2] = ~i[1:0];
            b[11] = 8'h10 + 8'(8 * (i % 7));
            ok = (i % 4 == 1) || (i % 4 == 2);
            if (ok) exp_opt = decode();
            q.push_back('{!ok, exp_opt});
            for (int k = 0; k < PRM_LEN; k++) wreg(8'(k), b[k]);
            go(8'h03);
            rreg(REG_STAT, 8'h0f, {4'h0, !ok, 3'h6});
        end
        q.push_back('{1'b1, exp_opt});
        go(8'h03);
        $display("block test done");
        wreg(REG_CTRL, 8'h04);
        wreg(8'h0b, 8'h11);
        wreg(REG_CTRL, 8'h03);
        repeat (20) @(posedge mclk);
        rreg(REG_STAT, 8'h10, 8'h10);
        wreg(REG_CTRL, 8'h04);
        q.push_back('{1'b0, exp_opt});
        go(8'h01);
        chk(prm_locked, 1'b1);
        wreg(8'h0a, 8'h06);
        wreg(8'h0b, 8'h20);
        q.push_back('{1'b1, exp_opt});
        go(8'h03);
        $display("refusal test done");
        for (int j = 0; j < 2; j++) begin
            lo = exp_opt;
            lo.fb_react = j ? REACT_HOLD : REACT_ZERO;
            lo.tb_react = j ? REACT_ZERO : REACT_HOLD;
            lo.diag_len = 8'h18;
            loc_opt <= lo;
            loc_wr <= 1'b1;
            tb_out_in <= 8'($urandom);
            dp_in_in <= 8'($urandom);
            diag_want <= 8'($urandom);
            @(posedge mclk);
            loc_wr <= 1'b0;
            repeat (2) @(posedge mclk);
            hold_tb = tb_out_in;
            hold_dp = dp_in_in;
            fb_fault <= 1'b1;
            tb_fault <= 1'b1;
            tb_out_in <= ~tb_out_in;
            dp_in_in <= ~dp_in_in;
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            chk(tb_out, j ? hold_tb : 8'h00);
            chk(dp_in, j ? 8'h00 : hold_dp);
            chk(diag_grant, diag_want < 8'h18 ? diag_want : 8'h18);
            @(posedge mclk);
            fb_fault <= 1'b0;
            tb_fault <= 1'b0;
        end
        $display("reaction test done");
        for (int j = 0; j < 2; j++) begin
            lo = exp_opt;
            lo.wd_1ms = j[0];
            loc_opt <= lo;
            loc_wr <= 1'b1;
            wd_units <= j ? 8'h03 : 8'h02;
            data_ex <= 1'b1;
            wait_n = j ? 3 * TICK_FAST : 2 * TICK_SLOW;
            @(posedge mclk);
            loc_wr <= 1'b0;
            data_ex <= 1'b0;
            repeat (wait_n - 1) @(posedge mclk);
            @(negedge mclk);
            chk(wd_expired, 1'b0);
            @(posedge mclk);
            @(negedge mclk);
            chk(wd_expired, 1'b1);
            @(posedge mclk);
        end
        data_ex <= 1'b1;
        @(posedge mclk);
        data_ex <= 1'b0;
        wd_units <= 8'h00;
        @(negedge mclk);
        chk(wd_expired, 1'b0);
        $display("watchdog test done");
        chk(32'(q.size()), 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
